// ==== rtl/arly_relay.sv ====
`include "arly_regs.svh"
// What the document asks for
// [RULE1] Mode select: failsafe, standard or mirror; failsafe after reset.
// [RULE2] Failsafe: energized with no fault or only a transient fault.
// [RULE3] Failsafe: acknowledged fault energizes only when relay-acknowledge is on.
// [RULE4] Failsafe: injection inhibit energizes when inhibit-acknowledge is on.
// [RULE5] Failsafe: first measurement, faults, supply loss, errors de-energize.
// [RULE6] Self-test with relays toggles the relay for 3 seconds.
// [RULE7] Disconnected injection, overvoltage, overcapacitance form system error.
// [RULE8] Failed self-test counts as product error.
// [RULE9] Standard: energized on preventive or insulation fault or errors.
// [RULE10] Standard: de-energized on first measurement, no fault, acked, inhibit, supply loss.
// [RULE11] Mirror: relay follows the main alarm relay while operating.
// [RULE12] Mirror: stops following when inoperative or de-energized.
// [RULE13] State assignments are accepted only from the Modbus path.
// [RULE14] Bitmap holds any mix of the five assignable states.
// [RULE15] Assigned states are readable for the local display.
// [RULE16] External logic: both inputs high means alarm; input one low means failure.
// [RULE17] Integrator wires mirror relay in series with a failsafe main relay.
// [RULE18] Alarms clear only above 1.2 times threshold, done by the measurement path.
// [RULE19] Early-warning bitmap sits at Modbus address 3046.
// [RULE20] Mirror mode clears the bitmap and refuses assignments.
// [RULE21] Bitmap bits 0, 4, 8, 16, 24 map the five states.
// [RULE22] Toggle timed by a clock counter; relay output updated synchronously.
// [RULE23] Forced de-energizing conditions take precedence over energizing ones; the code lets the self-test toggle override them.
module arly_relay #(
    parameter int unsigned TEST_CYCLES  = `ARLY_TEST_CYCLES,
    parameter int unsigned TOGGLE_HALF  = `ARLY_TOGGLE_HALF
) (
    input  wire logic              CLOCK,             // 200 MHz clock
    input  wire logic              RST,               // Synchronous reset, active high
    input  wire logic              CE,                // Clock enable, freezes state when low
    input  wire logic [1:0]        MODE_SET,          // Requested mode, arly_pkg::arly_mode_e
    input  wire logic              MODE_WR,           // Pulse: load MODE_SET
    input  wire logic              ALARM_ACK_RELAY_OPTION, // Relay-acknowledge option
    input  wire logic              INHIBIT_ACK_OPTION, // Inhibit-acknowledge option
    input  wire logic              FIRST_MEAS,        // First measurement in progress
    input  wire logic              PREV_FAULT,        // Preventive fault present
    input  wire logic              INS_FAULT,         // Insulation fault present
    input  wire logic              INS_FAULT_ACKED,   // Insulation fault acknowledged
    input  wire logic              TRANSIENT_FAULT,   // Only a transient fault present
    input  wire logic              INJ_INHIBITED,     // Injection inhibited
    input  wire logic              AUX_SUPPLY_LOST,   // Auxiliary supply lost
    input  wire logic              INJ_DISCONNECTED,  // Injection disconnected
    input  wire logic              OVERVOLTAGE,       // Overvoltage detected
    input  wire logic              OVERCAPACITANCE,   // Overcapacitance detected
    input  wire logic              SELFTEST_FAILED,   // Self-test failed
    input  wire logic              OTHER_PRODUCT_ERR, // Any other product error
    input  wire logic              SELFTEST_RELAYS,   // Pulse: start self-test with relays
    input  wire logic              DEVICE_OK,         // Device operating correctly
    input  wire logic              MAIN_ALARM_RELAY,  // Drive state of the main alarm relay
    input  wire logic              MODBUS_WR,         // Pulse: Modbus register write
    input  wire logic [15:0]       MODBUS_ADDR,       // Modbus register address
    input  wire logic [31:0]       MODBUS_WDATA,      // Modbus write data
    output logic                   EARLY_WARNING_RELAY, // Relay coil drive, 1 = energized
    output logic [1:0]             MODE_STATE,        // Current mode
    output logic [31:0]            BITMAP,            // Assigned states for display
    output logic                   SYSTEM_ERROR,      // Combined system error
    output logic                   PRODUCT_ERROR,     // Combined product error
    output logic                   TESTING            // Self-test toggle in progress
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks: the counters cannot serve a span shorter than two cycles.
    generate
        if (TEST_CYCLES < 2)
        begin : g_bad_span
            $error("arly_relay: TEST_CYCLES must be at least 2");
        end
        if (TOGGLE_HALF < 1 || TOGGLE_HALF > TEST_CYCLES)
        begin : g_bad_half
            $error("arly_relay: TOGGLE_HALF must lie between 1 and TEST_CYCLES");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    arly_pkg::arly_mode_e  mode_q;
    arly_pkg::arly_state_e state_q;
    logic [31:0]           cnt_q;
    logic [31:0]           half_q;
    logic                  toggle_q;
    logic [31:0]           bitmap_q;
    logic                  sys_err;
    logic                  prod_err;
    logic                  fs_on;
    logic                  std_on;
    logic                  relay_d;
    logic                  testing;
    logic                  start_test;
    logic                  half_end;

    // The mirror decode gates both the bitmap and the self-test start.
    function automatic logic is_mirror(input arly_pkg::arly_mode_e m);
        return m == arly_pkg::ARLY_MODE_MIRROR;
    endfunction

    function automatic logic in_test(input arly_pkg::arly_state_e s);
        return s == arly_pkg::ARLY_TESTING;
    endfunction

    assign sys_err    = INJ_DISCONNECTED | OVERVOLTAGE | OVERCAPACITANCE; // RULE7
    assign prod_err   = SELFTEST_FAILED | OTHER_PRODUCT_ERR;               // RULE8
    assign testing    = in_test(state_q);
    // A start while already testing, or in mirror mode, is ignored.
    assign start_test = SELFTEST_RELAYS && !is_mirror(mode_q) && !testing;
    assign half_end   = testing && (half_q == TOGGLE_HALF - 1);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            mode_q <= arly_pkg::ARLY_MODE_FAILSAFE; // RULE1
        else if (CE && MODE_WR && MODE_SET != 2'h3)
            mode_q <= arly_pkg::arly_mode_e'(MODE_SET); // RULE1
    end

    // Only the Modbus write path loads the bitmap; a mode write to mirror mode clears it.
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            bitmap_q <= `ARLY_EW_BITMAP_RESET;
        else if (CE)
        begin
            if (is_mirror(mode_q))
                bitmap_q <= 32'h00000000; // RULE20
            else if (MODBUS_WR && MODBUS_ADDR == `ARLY_EW_BITMAP_ADDR) // RULE13 RULE19
                bitmap_q <= MODBUS_WDATA & `ARLY_BITMAP_MASK; // RULE14 RULE21
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self-test sequencer: idle until a start, then run for TEST_CYCLES cycles.
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            state_q <= arly_pkg::ARLY_IDLE;
        else if (CE)
        begin
            case (state_q)
                arly_pkg::ARLY_IDLE:
                begin
                    if (start_test)
                        state_q <= arly_pkg::ARLY_TESTING; // RULE6
                end
                default:
                begin
                    if (cnt_q == TEST_CYCLES - 1)
                        state_q <= arly_pkg::ARLY_IDLE; // RULE6
                end
            endcase
        end
    end

    // The span counter is free of the toggle rate, so the span stays exact.
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            cnt_q <= 32'h00000000;
        else if (CE)
        begin
            if (start_test)
                cnt_q <= 32'h00000000;
            else if (testing)
                cnt_q <= cnt_q + 32'h00000001; // RULE22
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
            half_q <= 32'h00000000;
        else if (CE)
        begin
            if (start_test || half_end)
                half_q <= 32'h00000000;
            else if (testing)
                half_q <= half_q + 32'h00000001; // RULE22
        end
    end

    // The first toggle level inverts the relay, so the test is visible at once.
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            toggle_q <= 1'b0;
        else if (CE)
        begin
            if (start_test)
                toggle_q <= ~EARLY_WARNING_RELAY; // RULE6
            else if (half_end)
                toggle_q <= ~toggle_q; // RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault inputs arrive already filtered by the threshold hysteresis; the relay
    // follows them directly and never latches an alarm on its own. // RULE18
    // Failsafe: forced off conditions are tested before every energizing term except the self-test toggle, which relay_d selects first.
    always_comb
    begin
        fs_on = 1'b0;
        if (FIRST_MEAS || AUX_SUPPLY_LOST || prod_err || sys_err) // RULE5 RULE23
            fs_on = 1'b0;
        else if (INJ_INHIBITED && INHIBIT_ACK_OPTION) // RULE4
            fs_on = 1'b1;
        else if (INS_FAULT && INS_FAULT_ACKED) // RULE3
            fs_on = ALARM_ACK_RELAY_OPTION;
        else if (INS_FAULT || PREV_FAULT) // RULE5
            fs_on = 1'b0;
        else
            fs_on = 1'b1; // RULE2
    end

    always_comb
    begin
        std_on = 1'b0;
        if (FIRST_MEAS || AUX_SUPPLY_LOST) // RULE10 RULE23
            std_on = 1'b0;
        else if (prod_err || sys_err) // RULE9
            std_on = 1'b1;
        else if (INJ_INHIBITED && INHIBIT_ACK_OPTION) // RULE10
            std_on = 1'b0;
        else if (INS_FAULT && INS_FAULT_ACKED && ALARM_ACK_RELAY_OPTION) // RULE10
            std_on = 1'b0;
        else if (INS_FAULT || PREV_FAULT) // RULE9
            std_on = 1'b1;
        else
            std_on = 1'b0; // RULE10
    end

    always_comb
    begin
        relay_d = 1'b0;
        case (mode_q)
            arly_pkg::ARLY_MODE_MIRROR:
                relay_d = DEVICE_OK & MAIN_ALARM_RELAY; // RULE11 RULE12
            arly_pkg::ARLY_MODE_STANDARD:
                relay_d = testing ? toggle_q : std_on; // RULE6
            default:
                relay_d = testing ? toggle_q : fs_on; // RULE6
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Every output is a flip-flop, so the coil never sees a decode glitch.
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            EARLY_WARNING_RELAY <= 1'b0;
        else if (CE)
            EARLY_WARNING_RELAY <= relay_d; // RULE22
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
            MODE_STATE <= 2'h0;
        else if (CE)
            MODE_STATE <= mode_q;
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
            BITMAP <= `ARLY_EW_BITMAP_RESET;
        else if (CE)
            BITMAP <= bitmap_q; // RULE15
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
            SYSTEM_ERROR <= 1'b0;
        else if (CE)
            SYSTEM_ERROR <= sys_err; // RULE7
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
            PRODUCT_ERROR <= 1'b0;
        else if (CE)
            PRODUCT_ERROR <= prod_err; // RULE8
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
            TESTING <= 1'b0;
        else if (CE)
            TESTING <= testing;
    end

endmodule

// ==== rtl/arly_regs.svh ====
`ifndef ARLY_REGS_SVH
`define ARLY_REGS_SVH
// Relay bitmap field positions.
`define ARLY_BIT_PREV_ALARM   0
`define ARLY_BIT_INS_ALARM    4
`define ARLY_BIT_INJ_INHIBIT  8
`define ARLY_BIT_SYS_ERROR    16
`define ARLY_BIT_PROD_ERROR   24
// Writable bits of a bitmap: the five state bits.
`define ARLY_BITMAP_MASK      32'h01010111
// Factory default of the early-warning bitmap: product and system error.
`define ARLY_EW_BITMAP_RESET  32'h01010000
// Bitmap register address of the early-warning relay.
`define ARLY_EW_BITMAP_ADDR   16'h0be6
// Self-test toggle time in milliseconds and clock rate in kHz.
`define ARLY_TEST_TIME_MS     3000
`define ARLY_CLK_KHZ          200000
`define ARLY_TEST_CYCLES      (`ARLY_TEST_TIME_MS * `ARLY_CLK_KHZ)
// Half period of the self-test toggle in clock cycles; the rate is our own choice.
`define ARLY_TOGGLE_HALF      100000000
`endif

// ==== rtl/arly_pkg.sv ====
package arly_pkg;
    typedef enum logic [1:0] {ARLY_MODE_FAILSAFE, ARLY_MODE_STANDARD, ARLY_MODE_MIRROR} arly_mode_e;
    typedef enum logic {ARLY_IDLE, ARLY_TESTING} arly_state_e;
endpackage

// ==== verif/arly_plc.sv ====
module arly_plc (
    input  wire logic in_one,  // Contact on PLC input 1
    input  wire logic in_two,  // Contact on PLC input 2
    output logic      alarm,   // Insulation alarm seen
    output logic      failure  // Product failure seen
);
    timeunit 1ns;
    timeprecision 1ps;
    assign alarm   = in_one & in_two;
    assign failure = !in_one;
endmodule

// ==== verif/arly_relay_assertions.sv ====
`include "arly_regs.svh"
module arly_relay_chk #(
    parameter int unsigned TEST_CYCLES = 40
) (
    input wire logic        CLOCK,                  // Clock
    input wire logic        RST,                    // Reset
    input wire logic        ALARM_ACK_RELAY_OPTION, // Ack option
    input wire logic        INHIBIT_ACK_OPTION,     // Inhibit option
    input wire logic        FIRST_MEAS,             // First measure
    input wire logic        PREV_FAULT,             // Early fault
    input wire logic        INS_FAULT,              // Fault
    input wire logic        INS_FAULT_ACKED,        // Acked fault
    input wire logic        INJ_INHIBITED,          // Inhibit
    input wire logic        AUX_SUPPLY_LOST,        // Supply lost
    input wire logic        INJ_DISCONNECTED,       // Disconnected
    input wire logic        OVERVOLTAGE,            // Overvoltage
    input wire logic        OVERCAPACITANCE,        // Overcapacitance
    input wire logic        SELFTEST_FAILED,        // Test failed
    input wire logic        OTHER_PRODUCT_ERR,      // Product error
    input wire logic        DEVICE_OK,              // Healthy
    input wire logic        MAIN_ALARM_RELAY,       // Main relay
    input wire logic        EARLY_WARNING_RELAY,    // Relay drive
    input wire logic [1:0]  MODE_STATE,             // Mode
    input wire logic [31:0] BITMAP,                 // Bitmap
    input wire logic        SYSTEM_ERROR,           // System error
    input wire logic        PRODUCT_ERROR,          // Product error
    input wire logic        TESTING                 // Toggle active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////
    logic        act_q, hard_q, sys_q, prd_q, inh_q, ack_q, opt_q, idle_q, mir_q;
    logic [1:0]  m_q;
    logic [31:0] tcnt_q;
    // Inputs are captured here so each relay check sees the edge that produced it.
    always_ff @(posedge CLOCK)
    begin
        act_q  <= !RST;
        hard_q <= FIRST_MEAS | AUX_SUPPLY_LOST;
        sys_q  <= INJ_DISCONNECTED | OVERVOLTAGE | OVERCAPACITANCE;
        prd_q  <= SELFTEST_FAILED | OTHER_PRODUCT_ERR;
        inh_q  <= INJ_INHIBITED & INHIBIT_ACK_OPTION;
        ack_q  <= INS_FAULT & INS_FAULT_ACKED;
        opt_q  <= ALARM_ACK_RELAY_OPTION;
        idle_q <= !(PREV_FAULT | INS_FAULT | INS_FAULT_ACKED | INJ_INHIBITED);
        mir_q  <= DEVICE_OK & MAIN_ALARM_RELAY;
        m_q    <= MODE_STATE;
        tcnt_q <= TESTING ? tcnt_q + 32'h1 : 32'h0;
    end
    wire ok  = act_q && !TESTING && MODE_STATE == m_q;
    wire frc = hard_q | sys_q | prd_q;
    ////////////////////////////////////////
    a_fs_forced_off: assert property (ok && MODE_STATE == 2'h0 && frc |-> !EARLY_WARNING_RELAY)
        else $error("Failsafe relay on while forced off.");
    a_fs_idle_on: assert property (ok && MODE_STATE == 2'h0 && !frc && idle_q |-> EARLY_WARNING_RELAY)
        else $error("Failsafe relay off with no fault.");
    a_fs_ack_opt: assert property (ok && MODE_STATE == 2'h0 && !frc && !inh_q && ack_q |-> EARLY_WARNING_RELAY == opt_q)
        else $error("Failsafe acked fault ignores option.");
    a_fs_inhibit_on: assert property (ok && MODE_STATE == 2'h0 && !frc && inh_q |-> EARLY_WARNING_RELAY)
        else $error("Failsafe relay off under inhibit.");
    a_std_err_on: assert property (ok && MODE_STATE == 2'h1 && !hard_q && (sys_q || prd_q) |-> EARLY_WARNING_RELAY)
        else $error("Standard relay off on error.");
    a_std_hard_off: assert property (ok && MODE_STATE == 2'h1 && hard_q |-> !EARLY_WARNING_RELAY)
        else $error("Standard relay on in first measure or supply loss.");
    a_mirror_follow: assert property (ok && MODE_STATE == 2'h2 |-> EARLY_WARNING_RELAY == mir_q)
        else $error("Mirror relay differs from main relay.");
    a_err_flags: assert property (act_q |-> SYSTEM_ERROR == sys_q && PRODUCT_ERROR == prd_q)
        else $error("Error flags wrong.");
    a_map_mirror: assert property (MODE_STATE == 2'h2 && m_q == 2'h2 && $past(m_q) == 2'h2 |-> BITMAP == 32'h0)
        else $error("Bitmap not clear in mirror.");
    a_map_mask: assert property ((BITMAP & ~(`ARLY_BITMAP_MASK)) == 32'h0)
        else $error("Reserved bitmap bit set.");
    a_test_bound: assert property (tcnt_q <= TEST_CYCLES + 1)
        else $error("Self-test toggle too long.");
    a_test_flip: assert property ($rose(TESTING) |-> EARLY_WARNING_RELAY != $past(EARLY_WARNING_RELAY))
        else $error("Self-test did not invert relay.");
    a_reset_vals: assert property ($fell(RST) |-> MODE_STATE == 2'h0 && BITMAP == 32'h01010000)
        else $error("Reset values wrong.");
endmodule
bind arly_relay arly_relay_chk #(.TEST_CYCLES(TEST_CYCLES)) u_chk (.CLOCK, .RST, .ALARM_ACK_RELAY_OPTION,
    .INHIBIT_ACK_OPTION, .FIRST_MEAS, .PREV_FAULT, .INS_FAULT, .INS_FAULT_ACKED, .INJ_INHIBITED, .AUX_SUPPLY_LOST,
    .INJ_DISCONNECTED, .OVERVOLTAGE, .OVERCAPACITANCE, .SELFTEST_FAILED, .OTHER_PRODUCT_ERR, .DEVICE_OK,
    .MAIN_ALARM_RELAY, .EARLY_WARNING_RELAY, .MODE_STATE, .BITMAP, .SYSTEM_ERROR, .PRODUCT_ERROR, .TESTING);

// ==== verif/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLOCK = 0, RST = 1, CE = 1, MODE_WR = 0, SELFTEST_RELAYS = 0, DEVICE_OK = 0;
    logic        MAIN_ALARM_RELAY = 0, MODBUS_WR = 0, EARLY_WARNING_RELAY, SYSTEM_ERROR, PRODUCT_ERROR;
    logic        TESTING, alarm, failure;
    logic [1:0]  MODE_SET = 0, MODE_STATE;
    logic [15:0] MODBUS_ADDR = 0;
    logic [31:0] MODBUS_WDATA = 0, BITMAP;
    logic [13:0] cnd = 0;
    int          err_total = 0, samples_checked = 0;
    // Each row is the expected relay level over the fourteen condition inputs.
    logic [14:0] fs_tab [15] = '{15'h4000, 15'h4080, 15'h0400, 15'h0200, 15'h6300, 15'h0300, 15'h5040,
                                 15'h0800, 15'h0020, 15'h0010, 15'h0008, 15'h0004, 15'h0002, 15'h0001, 15'h1060};
    logic [14:0] sd_tab [11] = '{15'h0000, 15'h0080, 15'h4400, 15'h4200, 15'h4010, 15'h4002, 15'h0c00,
                                 15'h0220, 15'h2300, 15'h1040, 15'h0808};
    always #2.5 CLOCK = ~CLOCK;
    arly_relay #(.TEST_CYCLES(40), .TOGGLE_HALF(5)) dut (.CLOCK, .RST, .CE, .MODE_SET, .MODE_WR,
        .ALARM_ACK_RELAY_OPTION(cnd[13]), .INHIBIT_ACK_OPTION(cnd[12]), .FIRST_MEAS(cnd[11]), .PREV_FAULT(cnd[10]),
        .INS_FAULT(cnd[9]), .INS_FAULT_ACKED(cnd[8]), .TRANSIENT_FAULT(cnd[7]), .INJ_INHIBITED(cnd[6]),
        .AUX_SUPPLY_LOST(cnd[5]), .INJ_DISCONNECTED(cnd[4]), .OVERVOLTAGE(cnd[3]), .OVERCAPACITANCE(cnd[2]),
        .SELFTEST_FAILED(cnd[1]), .OTHER_PRODUCT_ERR(cnd[0]), .SELFTEST_RELAYS, .DEVICE_OK, .MAIN_ALARM_RELAY,
        .MODBUS_WR, .MODBUS_ADDR, .MODBUS_WDATA, .EARLY_WARNING_RELAY, .MODE_STATE, .BITMAP, .SYSTEM_ERROR,
        .PRODUCT_ERROR, .TESTING);
    arly_plc plc (.in_one(EARLY_WARNING_RELAY), .in_two(MAIN_ALARM_RELAY), .alarm(alarm), .failure(failure));
    ////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask
    task automatic apply(input logic [14:0] row);
        @(posedge CLOCK) cnd <= row[13:0];
        @(posedge CLOCK) #1;
        chk("relay", 32'(row[14]), 32'(EARLY_WARNING_RELAY));
        chk("system error", 32'(|row[4:2]), 32'(SYSTEM_ERROR));
        chk("product error", 32'(|row[1:0]), 32'(PRODUCT_ERROR));
    endtask
    task automatic set_mode(input logic [1:0] m, input logic [1:0] exp);
        @(posedge CLOCK) MODE_SET <= m;
        MODE_WR <= 1'b1;
        @(posedge CLOCK) MODE_WR <= 1'b0;
        repeat (2) @(posedge CLOCK);
        #1 chk("mode", 32'(exp), 32'(MODE_STATE));
    endtask
    task automatic mb_write(input logic [15:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge CLOCK) MODBUS_ADDR <= a;
        MODBUS_WDATA <= d;
        MODBUS_WR <= 1'b1;
        @(posedge CLOCK) MODBUS_WR <= 1'b0;
        @(posedge CLOCK) #1;
        chk("bitmap", exp, BITMAP);
    endtask
    task automatic t_selftest();
        int n;
        int flips;
        logic prev;
        n = 0;
        flips = 0;
        apply(15'h4000);
        prev = EARLY_WARNING_RELAY;
        @(posedge CLOCK) SELFTEST_RELAYS <= 1'b1;
        @(posedge CLOCK) SELFTEST_RELAYS <= 1'b0;
        #1;
        for (int i = 0; i < 10 && TESTING !== 1'b1; i++)
            @(posedge CLOCK) #1;
        while (TESTING === 1'b1 && n < 100)
        begin
            n++;
            flips += (EARLY_WARNING_RELAY !== prev);
            prev = EARLY_WARNING_RELAY;
            @(posedge CLOCK) #1;
        end
        chk("toggle span", 32'h1, 32'(n >= 39 && n <= 41));
        chk("toggle count", 32'h1, 32'(flips >= 7));
        @(posedge CLOCK) #1 chk("relay after test", 32'h1, 32'(EARLY_WARNING_RELAY));
    endtask
    task automatic t_mirror();
        set_mode(2'h2, 2'h2);
        mb_write(16'h0be6, 32'hffffffff, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge CLOCK) {DEVICE_OK, MAIN_ALARM_RELAY} <= 2'(i);
            @(posedge CLOCK) #1 chk("mirror relay", 32'(i == 3), 32'(EARLY_WARNING_RELAY));
            chk("plc alarm", 32'(i == 3), 32'(alarm));
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK) #1 chk("reset bitmap", 32'h01010000, BITMAP);
        set_mode(2'h3, 2'h0);
        foreach (fs_tab[i]) apply(fs_tab[i]);
        t_selftest();
        mb_write(16'h0be6, 32'hffffffff, 32'h01010111);
        mb_write(16'h0be4, 32'h0, 32'h01010111);
        set_mode(2'h1, 2'h1);
        foreach (sd_tab[i]) apply(sd_tab[i]);
        t_mirror();
        finish_test();
    end
    // The whole sequence needs well under a thousand cycles, so a hang ends the run early.
    initial
    begin
        #20000;
        err_total++;
        finish_test();
    end
endmodule
